// >>> hdl/mss_pkg.sv
// constants and types for the media stream sender
package mss_pkg;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int US_NS          = 1000;
  localparam int CYC_PER_US     = US_NS / CLK_PERIOD_NS;
  localparam int PTIME_LONG_NS  = 1000000;
  localparam int PTIME_SHORT_NS = 125000;
  localparam int PTIME_LONG_CYC  = PTIME_LONG_NS / CLK_PERIOD_NS;
  localparam int PTIME_SHORT_CYC = PTIME_SHORT_NS / CLK_PERIOD_NS;

  localparam logic [6:0]  PT_MIN = 7'h60;
  localparam logic [6:0]  PT_MAX = 7'h7f;
  localparam logic [31:0] MC_MIN = 32'he0000200;
  localparam logic [31:0] MC_MAX = 32'hefffffff;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PT     = 8'h04;
  localparam logic [7:0] OFS_P1_DST = 8'h08;
  localparam logic [7:0] OFS_P1_UDP = 8'h0c;
  localparam logic [7:0] OFS_P2_DST = 8'h10;
  localparam logic [7:0] OFS_P2_UDP = 8'h14;
  localparam logic [7:0] OFS_TROFF  = 8'h18;
  localparam logic [7:0] OFS_NCH    = 8'h1c;
  localparam logic [7:0] OFS_CHORD  = 8'h20;
  localparam logic [7:0] OFS_CHS_LO = 8'h24;
  localparam logic [7:0] OFS_CHS_HI = 8'h28;
  localparam logic [7:0] OFS_STAT   = 8'h2c;
  localparam logic [7:0] OFS_UTIL   = 8'h30;
  localparam logic [7:0] OFS_SEQ    = 8'h34;

  localparam int CTRL_EN  = 0;
  localparam int CTRL_P1  = 1;
  localparam int CTRL_P2  = 2;
  localparam int CTRL_AUD = 3;
  localparam int CTRL_BPM = 4;
  localparam int CTRL_MAN = 5;
  localparam int CTRL_SHT = 6;
  localparam int CTRL_SRC = 8;
  localparam logic [10:0] CTRL_RST = 11'h000;

  localparam int ST_CFG_REF = 0;
  localparam int ST_AUTODIS = 1;
  localparam int ST_CHO_REF = 2;

  localparam logic [10:0] UDP_LIMIT  = 11'h5b4;
  localparam logic [10:0] RTP_HDR    = 11'h00c;
  localparam logic [10:0] SRD_HDR    = 11'h008;
  localparam logic [10:0] BPM_BLOCK  = 11'h0b4;
  localparam logic [10:0] BPM_BLOCKS = 11'h007;
  localparam logic [10:0] GPM_PAY    = UDP_LIMIT - RTP_HDR - SRD_HDR;
  localparam logic [10:0] BPM_PAY    = 11'(BPM_BLOCK * BPM_BLOCKS);

  localparam logic [5:0]  SPC_LONG   = 6'h30;
  localparam logic [5:0]  SPC_SHORT  = 6'h06;
  localparam logic [4:0]  NCH_MAX    = 5'h10;
  localparam logic [4:0]  NCH_RST    = 5'h02;
  localparam logic [1:0]  AUD_BYTES  = 2'h3;
  localparam logic [15:0] PORT_CAP   = 16'h2710;
  localparam logic [15:0] PORT_RSV   = 16'h0514;
  localparam logic [15:0] VID_BUDGET = PORT_CAP - PORT_RSV;

  localparam logic [1:0] CHO_ADD   = 2'h1;
  localparam logic [1:0] CHO_CLEAR = 2'h2;
  localparam logic [1:0] CHO_APPLY = 2'h3;

  typedef enum logic [1:0] {VS_IDLE, VS_WAIT, VS_SEND} mss_vid_st_t;
  typedef enum logic [2:0] {SYM_U, SYM_M, SYM_DM, SYM_ST, SYM_LT, SYM_51, SYM_71, SYM_SG}
    mss_sym_t;
endpackage

// >>> hdl/mss_sender.sv
// media stream sender: rtp/udp/ipv4 header builder, pacing and stream configuration
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module mss_sender #(
  parameter int P_LONG_CYC  = mss_pkg::PTIME_LONG_CYC,
  parameter int P_SHORT_CYC = mss_pkg::PTIME_SHORT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_frame_start,
  input  wire logic        i_vblank,
  input  wire logic        i_vid_pkt_rdy,
  input  wire logic [31:0] i_vid_ts,
  input  wire logic [15:0] i_troff_dflt,
  input  wire logic [15:0] i_src_bw,
  input  wire logic        i_fmt_chg,
  input  wire logic [5:0]  i_src_levelb,
  output logic             o_vid_pkt_take,
  output logic             o_tx1_valid,
  output logic             o_tx2_valid,
  output logic      [6:0]  o_pt,
  output logic      [15:0] o_seq,
  output logic      [31:0] o_ts,
  output logic      [10:0] o_pay_len,
  output logic      [5:0]  o_spc,
  output logic      [31:0] o_tx1_dst_ip,
  output logic      [15:0] o_tx1_src_port,
  output logic      [15:0] o_tx1_dst_port,
  output logic      [31:0] o_tx2_dst_ip,
  output logic      [15:0] o_tx2_src_port,
  output logic      [15:0] o_tx2_dst_port,
  output logic      [15:0] o_util_mbps
);

  function automatic logic [4:0] grp_ch(input logic [2:0] s);
    case (s)
      3'h1:    grp_ch = 5'h01;
      3'h2, 3'h3, 3'h4: grp_ch = 5'h02;
      3'h5:    grp_ch = 5'h06;
      3'h6:    grp_ch = 5'h08;
      3'h7:    grp_ch = 5'h04;
      default: grp_ch = 5'h00;
    endcase
  endfunction

  function automatic logic in_mc(input logic [31:0] ip);
    in_mc = (ip >= mss_pkg::MC_MIN) && (ip <= mss_pkg::MC_MAX);
  endfunction

  // codes 6 and 7 name no source, so they count as taken
  function automatic logic bad_src(input logic [2:0] s, input logic [5:0] lvb);
    logic [7:0] busy;
    busy    = {2'b11, lvb};
    bad_src = busy[s];
  endfunction

  // configuration registers
  logic [10:0] ctrl_q;
  logic [6:0]  pt_q;
  logic [31:0] p1_dst_q, p2_dst_q, p1_udp_q, p2_udp_q;
  logic [15:0] troff_q;
  logic [4:0]  nch_q;
  logic [2:0]  stat_q;
  logic [63:0] cho_q;
  logic [3:0]  cho_cnt_q;
  logic [4:0]  cho_used_q;
  logic [15:0] util_q;

  wire en   = ctrl_q[mss_pkg::CTRL_EN];
  wire p1en = ctrl_q[mss_pkg::CTRL_P1];
  wire p2en = ctrl_q[mss_pkg::CTRL_P2];
  wire aud  = ctrl_q[mss_pkg::CTRL_AUD];
  wire [2:0] src = ctrl_q[mss_pkg::CTRL_SRC +: 3];

  wire wr_ctrl  = i_wr && (i_addr == mss_pkg::OFS_CTRL);
  wire wr_pt    = i_wr && (i_addr == mss_pkg::OFS_PT);
  wire wr_p1d   = i_wr && (i_addr == mss_pkg::OFS_P1_DST);
  wire wr_p1u   = i_wr && (i_addr == mss_pkg::OFS_P1_UDP);
  wire wr_p2d   = i_wr && (i_addr == mss_pkg::OFS_P2_DST);
  wire wr_p2u   = i_wr && (i_addr == mss_pkg::OFS_P2_UDP);
  wire wr_troff = i_wr && (i_addr == mss_pkg::OFS_TROFF);
  wire wr_nch   = i_wr && (i_addr == mss_pkg::OFS_NCH);
  wire wr_cho   = i_wr && (i_addr == mss_pkg::OFS_CHORD);
  wire wr_stat  = i_wr && (i_addr == mss_pkg::OFS_STAT);

  // checks on written values; a refused write keeps the old value and flags it
  wire [6:0] w_pt  = i_wdata[6:0];
  wire pt_ok  = (i_wdata[31:7] == 25'h0) && (w_pt >= mss_pkg::PT_MIN);
  wire dst_ok = in_mc(i_wdata);
  wire [4:0] w_nch = i_wdata[4:0];
  wire nch_ok = (i_wdata[31:5] == 27'h0) && ((w_nch == 5'h01) || (w_nch == 5'h02) ||
                (w_nch == 5'h04) || (w_nch == 5'h06) || (w_nch == 5'h08) ||
                (w_nch == mss_pkg::NCH_MAX));
  wire w_vid_on = i_wdata[mss_pkg::CTRL_EN] && !i_wdata[mss_pkg::CTRL_AUD];
  wire ctl_ok = !(w_vid_on && (bad_src(i_wdata[mss_pkg::CTRL_SRC +: 3], i_src_levelb) ||
                (i_src_bw > mss_pkg::VID_BUDGET)));
  // a level b source grabbed while video is enabled (not in audio mode) also stops the stream
  wire lvb_now  = en && !aud && bad_src(src, i_src_levelb);
  wire over_sub = en && !aud && i_fmt_chg && (i_src_bw > mss_pkg::VID_BUDGET);
  wire auto_dis = lvb_now || over_sub;

  wire [10:0] ctrl_w = ctl_ok ? i_wdata[10:0] : ctrl_q;
  wire [10:0] ctrl_d = (wr_ctrl ? ctrl_w : ctrl_q) & ~{10'h000, auto_dis};

  // channel order string: eight slots of {symbol, channel count}
  wire [1:0] cho_cmd = i_wdata[1:0];
  wire [2:0] cho_sym = i_wdata[6:4];
  wire [4:0] remain  = nch_q - cho_used_q;
  wire [5:0] fit_sum = {1'b0, cho_used_q} + {1'b0, grp_ch(cho_sym)};
  wire cho_room  = cho_cnt_q < 4'h8;
  wire add_ok    = cho_room && (cho_sym != 3'h0) && (fit_sum <= {1'b0, nch_q});
  wire cho_bad   = wr_cho && (((cho_cmd == mss_pkg::CHO_ADD) && !add_ok) ||
                   ((cho_cmd == mss_pkg::CHO_APPLY) && (remain != 5'h0) && !cho_room));
  logic [63:0] cho_d;
  logic [3:0]  cho_cnt_d;
  logic [4:0]  cho_used_d;

  always_comb begin
    cho_d      = cho_q;
    cho_cnt_d  = cho_cnt_q;
    cho_used_d = cho_used_q;
    if (wr_nch && nch_ok) begin
      cho_d      = {56'h0, 3'h0, w_nch};
      cho_cnt_d  = 4'h1;
      cho_used_d = w_nch;
    end else if (wr_cho && (cho_cmd == mss_pkg::CHO_CLEAR)) begin
      cho_d      = 64'h0;
      cho_cnt_d  = 4'h0;
      cho_used_d = 5'h0;
    end else if (wr_cho && (cho_cmd == mss_pkg::CHO_ADD) && add_ok) begin
      cho_d[cho_cnt_q[2:0]*8 +: 8] = {cho_sym, grp_ch(cho_sym)};
      cho_cnt_d  = cho_cnt_q + 4'h1;
      cho_used_d = fit_sum[4:0];
    end else if (wr_cho && (cho_cmd == mss_pkg::CHO_APPLY) && (remain != 5'h0) &&
                 cho_room) begin
      cho_d[cho_cnt_q[2:0]*8 +: 8] = {3'h0, remain};
      cho_cnt_d  = cho_cnt_q + 4'h1;
      cho_used_d = nch_q;
    end
  end

  wire cfg_bad = (wr_pt && !pt_ok) || ((wr_p1d || wr_p2d) && !dst_ok) ||
                 (wr_nch && !nch_ok) || (wr_ctrl && !ctl_ok);
  // hardware set beats the software clear in the same cycle
  wire [2:0] stat_set = {cho_bad, auto_dis, cfg_bad};
  wire [2:0] stat_d   = (stat_q & ~(wr_stat ? i_wdata[2:0] : 3'h0)) | stat_set;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q     <= mss_pkg::CTRL_RST;
      pt_q       <= mss_pkg::PT_MIN;
      p1_dst_q   <= mss_pkg::MC_MIN;
      p2_dst_q   <= mss_pkg::MC_MIN;
      p1_udp_q   <= 32'h0;
      p2_udp_q   <= 32'h0;
      troff_q    <= 16'h0;
      nch_q      <= mss_pkg::NCH_RST;
      stat_q     <= 3'h0;
      cho_q      <= {56'h0, 3'h0, mss_pkg::NCH_RST};
      cho_cnt_q  <= 4'h1;
      cho_used_q <= mss_pkg::NCH_RST;
    end else begin
      ctrl_q     <= ctrl_d;
      pt_q       <= (wr_pt && pt_ok) ? w_pt : pt_q;
      p1_dst_q   <= (wr_p1d && dst_ok) ? i_wdata : p1_dst_q;
      p2_dst_q   <= (wr_p2d && dst_ok) ? i_wdata : p2_dst_q;
      p1_udp_q   <= wr_p1u ? i_wdata : p1_udp_q;
      p2_udp_q   <= wr_p2u ? i_wdata : p2_udp_q;
      troff_q    <= wr_troff ? i_wdata[15:0] : troff_q;
      nch_q      <= (wr_nch && nch_ok) ? w_nch : nch_q;
      stat_q     <= stat_d;
      cho_q      <= cho_d;
      cho_cnt_q  <= cho_cnt_d;
      cho_used_q <= cho_used_d;
    end
  end

  // pacing
  wire stream_on = en && (p1en || p2en);
  wire short_pt  = ctrl_q[mss_pkg::CTRL_SHT] || (nch_q == mss_pkg::NCH_MAX);
  wire [5:0] spc = short_pt ? mss_pkg::SPC_SHORT : mss_pkg::SPC_LONG;
  wire [15:0] aud_period = short_pt ? 16'(P_SHORT_CYC) : 16'(P_LONG_CYC);
  logic [15:0] aud_cnt_q;
  wire aud_tick = stream_on && aud && (aud_cnt_q >= aud_period - 16'h1);
  wire [15:0] aud_cnt_d = (!stream_on || !aud || aud_tick) ? 16'h0 : aud_cnt_q + 16'h1;

  wire [15:0] troff_us  = ctrl_q[mss_pkg::CTRL_MAN] ? troff_q : i_troff_dflt;
  wire [21:0] troff_cyc = 22'(troff_us * mss_pkg::CYC_PER_US);
  mss_pkg::mss_vid_st_t vs_q, vs_d;
  logic [21:0] vwait_q;
  wire vid_run = stream_on && !aud;
  // gapped schedule: blanking lines carry no packets
  assign o_vid_pkt_take = vid_run && (vs_q == mss_pkg::VS_SEND) && i_vid_pkt_rdy &&
                          !i_vblank;
  wire tx_go = o_vid_pkt_take || aud_tick;

  always_comb begin
    vs_d = vs_q;
    case (vs_q)
      mss_pkg::VS_IDLE: if (vid_run && i_frame_start) vs_d = mss_pkg::VS_WAIT;
      mss_pkg::VS_WAIT: if (vwait_q + 22'h1 >= troff_cyc) vs_d = mss_pkg::VS_SEND;
      mss_pkg::VS_SEND: if (i_frame_start) vs_d = mss_pkg::VS_WAIT;
      default:          vs_d = mss_pkg::VS_IDLE;
    endcase
    if (!vid_run) vs_d = mss_pkg::VS_IDLE;
  end
  wire [21:0] vwait_d = (vs_d == mss_pkg::VS_WAIT && vs_q == mss_pkg::VS_WAIT) ?
                        vwait_q + 22'h1 : 22'h0;

  // payload length per mode
  // widen first: 48 samples times 2 channels times 3 bytes overflows six bits
  wire [10:0] aud_len = 11'(spc) * 11'(nch_q) * 11'(mss_pkg::AUD_BYTES);
  wire [10:0] vid_len = ctrl_q[mss_pkg::CTRL_BPM] ? mss_pkg::BPM_PAY
                                                  : mss_pkg::GPM_PAY;
  wire [10:0] pay_len = aud ? aud_len : vid_len;
  logic [15:0] seq_q;
  logic [31:0] ts_q;
  wire [31:0] ts_d = aud ? ts_q + {26'h0, spc} : i_vid_ts;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aud_cnt_q <= 16'h0;
      vs_q      <= mss_pkg::VS_IDLE;
      vwait_q   <= 22'h0;
      seq_q     <= 16'h0;
      ts_q      <= 32'h0;
      util_q    <= 16'h0;
    end else begin
      aud_cnt_q <= aud_cnt_d;
      vs_q      <= vs_d;
      vwait_q   <= vwait_d;
      seq_q     <= tx_go ? seq_q + 16'h1 : seq_q;
      ts_q      <= tx_go ? ts_d : ts_q;
      util_q    <= (en && !aud) ? i_src_bw : 16'h0;
    end
  end

  // header outputs: one shared rtp set feeds both port copies
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx1_valid    <= 1'b0;
      o_tx2_valid    <= 1'b0;
      o_pt           <= mss_pkg::PT_MIN;
      o_seq          <= 16'h0;
      o_ts           <= 32'h0;
      o_pay_len      <= 11'h0;
      o_spc          <= 6'h0;
      o_tx1_dst_ip   <= 32'h0;
      o_tx1_src_port <= 16'h0;
      o_tx1_dst_port <= 16'h0;
      o_tx2_dst_ip   <= 32'h0;
      o_tx2_src_port <= 16'h0;
      o_tx2_dst_port <= 16'h0;
    end else begin
      o_tx1_valid <= tx_go && p1en;
      o_tx2_valid <= tx_go && p2en;
      if (tx_go) begin
        o_pt           <= pt_q;
        o_seq          <= seq_q;
        o_ts           <= ts_d;
        o_pay_len      <= pay_len;
        o_spc          <= aud ? spc : 6'h0;
        o_tx1_dst_ip   <= p1_dst_q;
        o_tx1_src_port <= p1_udp_q[31:16];
        o_tx1_dst_port <= p1_udp_q[15:0];
        o_tx2_dst_ip   <= p2_dst_q;
        o_tx2_src_port <= p2_udp_q[31:16];
        o_tx2_dst_port <= p2_udp_q[15:0];
      end
    end
  end
  assign o_util_mbps = util_q;

  // register read port, unmapped reads zero
  logic [31:0] rd_word;
  always_comb begin
    case (i_addr)
      mss_pkg::OFS_CTRL:   rd_word = {21'h0, ctrl_q};
      mss_pkg::OFS_PT:     rd_word = {25'h0, pt_q};
      mss_pkg::OFS_P1_DST: rd_word = p1_dst_q;
      mss_pkg::OFS_P1_UDP: rd_word = p1_udp_q;
      mss_pkg::OFS_P2_DST: rd_word = p2_dst_q;
      mss_pkg::OFS_P2_UDP: rd_word = p2_udp_q;
      mss_pkg::OFS_TROFF:  rd_word = {16'h0, troff_q};
      mss_pkg::OFS_NCH:    rd_word = {27'h0, nch_q};
      mss_pkg::OFS_CHORD:  rd_word = {11'h0, remain, 4'h0, cho_cnt_q, 3'h0, cho_used_q};
      mss_pkg::OFS_CHS_LO: rd_word = cho_q[31:0];
      mss_pkg::OFS_CHS_HI: rd_word = cho_q[63:32];
      mss_pkg::OFS_STAT:   rd_word = {14'h0, vs_q, 6'h0, short_pt, stream_on, 5'h0, stat_q};
      mss_pkg::OFS_UTIL:   rd_word = {10'h0, spc, util_q};
      mss_pkg::OFS_SEQ:    rd_word = {16'h0, seq_q};
      default:             rd_word = 32'h0;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_rdata <= 32'h0;
    else          o_rdata <= i_rd ? rd_word : 32'h0;
  end

  // checks
  property p_pt_hdr;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_tx1_valid || o_tx2_valid |-> (o_pt >= mss_pkg::PT_MIN) && (o_pt <= mss_pkg::PT_MAX);
  endproperty
  a_pt_hdr: assert property (p_pt_hdr) else $error("payload type out of range");
  property p_dual;
    @(posedge i_clk) disable iff (!i_rst_n)
      tx_go && p1en && p2en |=> o_tx1_valid && o_tx2_valid;
  endproperty
  a_dual: assert property (p_dual) else $error("redundant copy missing");
  property p_dst;
    @(posedge i_clk) disable iff (!i_rst_n) in_mc(p1_dst_q) && in_mc(p2_dst_q);
  endproperty
  a_dst: assert property (p_dst) else $error("destination not multicast");
  property p_udp;
    @(posedge i_clk) disable iff (!i_rst_n)
      wr_p2u ##1 tx_go |=> o_tx2_src_port == $past(i_wdata[31:16], 2);
  endproperty
  a_udp: assert property (p_udp) else $error("udp port altered");
  property p_gate;
    @(posedge i_clk) disable iff (!i_rst_n) o_tx1_valid |-> $past(en && p1en);
  endproperty
  a_gate: assert property (p_gate) else $error("packet with port off");
  property p_util;
    @(posedge i_clk) disable iff (!i_rst_n) !en |=> o_util_mbps == 16'h0;
  endproperty
  a_util: assert property (p_util) else $error("disabled stream counted");
  property p_over;
    @(posedge i_clk) disable iff (!i_rst_n) over_sub |=> !en && stat_q[mss_pkg::ST_AUTODIS];
  endproperty
  a_over: assert property (p_over) else $error("over-subscription not disabled");
  property p_bpm;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_tx1_valid && !$past(aud) && $past(ctrl_q[mss_pkg::CTRL_BPM]) |-> o_pay_len == 11'h4ec;
  endproperty
  a_bpm: assert property (p_bpm) else $error("block payload size wrong");
  property p_vblank;
    @(posedge i_clk) disable iff (!i_rst_n) !aud && i_vblank |=> !o_tx1_valid && !o_tx2_valid;
  endproperty
  a_vblank: assert property (p_vblank) else $error("packet in blanking");
  property p_sixteen;
    @(posedge i_clk) disable iff (!i_rst_n) nch_q == mss_pkg::NCH_MAX |-> spc == 6'h06;
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("16 channels not short");
  c_dual: cover property (@(posedge i_clk) o_tx1_valid && o_tx2_valid);
  c_over: cover property (@(posedge i_clk) over_sub);
  c_apply: cover property (@(posedge i_clk)
    wr_cho && cho_cmd == mss_pkg::CHO_APPLY && remain != 5'h0);
  c_aud: cover property (@(posedge i_clk) aud_tick ##[1:300] aud_tick);
endmodule

// >>> test/mss_net_model.sv
// network side stand-in: counts the copies seen on each port
`timescale 1ns/10ps
module mss_net_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tx1_valid,
  input  wire logic        i_tx2_valid,
  output logic      [15:0] o_cnt1,
  output logic      [15:0] o_cnt2,
  output logic      [15:0] o_pairs
);
  // receivers only listen; a copy is one valid pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cnt1  <= 16'h0000;
      o_cnt2  <= 16'h0000;
      o_pairs <= 16'h0000;
    end else begin
      o_cnt1  <= o_cnt1 + 16'(i_tx1_valid);
      o_cnt2  <= o_cnt2 + 16'(i_tx2_valid);
      o_pairs <= o_pairs + 16'(i_tx1_valid & i_tx2_valid);
    end
  end
endmodule

// >>> test/test_mss_sender.sv
// self-checking bench for the media stream sender
`timescale 1ns/10ps
module test_mss_sender;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, i_vid_ts = 32'h0, o_rdata, o_tx1_dst_ip, o_tx2_dst_ip, o_ts;
  logic        i_frame_start = 1'b0, i_vblank = 1'b0, i_vid_pkt_rdy = 1'b0, i_fmt_chg = 1'b0;
  logic [15:0] i_troff_dflt = 16'h0001, i_src_bw = 16'h03e8, o_util_mbps, o_seq;
  logic [5:0]  i_src_levelb = 6'h00, o_spc;
  logic        o_vid_pkt_take, o_tx1_valid, o_tx2_valid;
  logic [6:0]  o_pt;
  logic [10:0] o_pay_len;
  logic [15:0] o_tx1_src_port, o_tx1_dst_port, o_tx2_src_port, o_tx2_dst_port;
  logic [15:0] cnt1, cnt2, pairs, vcnt = 16'h0;
  int          err_count = 0, checks = 0, ticks = 0;

  // short audio periods keep the run brief
  mss_sender #(.P_LONG_CYC(40), .P_SHORT_CYC(5)) mss_sender_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_frame_start(i_frame_start), .i_vblank(i_vblank),
    .i_vid_pkt_rdy(i_vid_pkt_rdy), .i_vid_ts(i_vid_ts), .i_troff_dflt(i_troff_dflt),
    .i_src_bw(i_src_bw), .i_fmt_chg(i_fmt_chg), .i_src_levelb(i_src_levelb),
    .o_vid_pkt_take(o_vid_pkt_take), .o_tx1_valid(o_tx1_valid), .o_tx2_valid(o_tx2_valid),
    .o_pt(o_pt), .o_seq(o_seq), .o_ts(o_ts), .o_pay_len(o_pay_len), .o_spc(o_spc),
    .o_tx1_dst_ip(o_tx1_dst_ip), .o_tx1_src_port(o_tx1_src_port),
    .o_tx1_dst_port(o_tx1_dst_port), .o_tx2_dst_ip(o_tx2_dst_ip),
    .o_tx2_src_port(o_tx2_src_port), .o_tx2_dst_port(o_tx2_dst_port),
    .o_util_mbps(o_util_mbps));
  mss_net_model mss_net_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx1_valid(o_tx1_valid),
    .i_tx2_valid(o_tx2_valid), .o_cnt1(cnt1), .o_cnt2(cnt2), .o_pairs(pairs));

  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_vid_pkt_take === 1'b1) vcnt <= vcnt + 16'h1;
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rng(input logic [15:0] d, input logic [15:0] lo, input logic [15:0] hi);
    chk({31'h0, (d >= lo && d <= hi)}, 32'h1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, e);
  endtask
  task automatic frame();
    @(posedge i_clk) i_frame_start <= 1'b1;
    @(posedge i_clk) i_frame_start <= 1'b0;
  endtask

  task automatic t_regs();
    rchk(mss_pkg::OFS_PT, 32'hff, 32'h60);
    wr(mss_pkg::OFS_PT, 32'h5f);
    rchk(mss_pkg::OFS_PT, 32'hff, 32'h60);
    rchk(mss_pkg::OFS_STAT, 32'h1, 32'h1);
    wr(mss_pkg::OFS_PT, 32'h7f);
    rchk(mss_pkg::OFS_PT, 32'hff, 32'h7f);
    wr(mss_pkg::OFS_P1_DST, 32'he00001ff);
    rchk(mss_pkg::OFS_P1_DST, 32'hffffffff, 32'he0000200);
    wr(mss_pkg::OFS_P1_DST, 32'hefffffff);
    rchk(mss_pkg::OFS_P1_DST, 32'hffffffff, 32'hefffffff);
    wr(mss_pkg::OFS_NCH, 32'h3);
    rchk(mss_pkg::OFS_NCH, 32'h1f, 32'h2);
    wr(mss_pkg::OFS_STAT, 32'h7);
    $display("register test done");
  endtask

  task automatic t_audio();
    logic [15:0] c;
    wr(mss_pkg::OFS_P1_UDP, 32'hffff0000);
    c = cnt1;
    wr(mss_pkg::OFS_CTRL, 32'h0f);
    cyc(400);
    wr(mss_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    rng(cnt1 - c, 16'd9, 16'd11);
    chk(32'(cnt2), 32'(cnt1));
    chk(32'(pairs), 32'(cnt1));
    chk(32'(o_spc), 32'h30);
    chk(32'(o_pay_len), 32'h120);
    chk(32'(o_pt), 32'h7f);
    chk({o_tx1_src_port, o_tx1_dst_port}, 32'hffff0000);
    chk(o_tx1_dst_ip, 32'hefffffff);
    chk(o_tx2_dst_ip, 32'he0000200);
    chk(32'(o_seq), 32'(cnt1) - 32'h1);
    chk(o_ts, 32'(cnt1) * 32'h30);
    c = cnt1;
    wr(mss_pkg::OFS_CTRL, 32'h4f);
    cyc(100);
    rng(cnt1 - c, 16'd18, 16'd21);
    chk(32'(o_spc), 32'h06);
    wr(mss_pkg::OFS_NCH, 32'h10);
    c = cnt1;
    wr(mss_pkg::OFS_CTRL, 32'h0f);
    cyc(100);
    rng(cnt1 - c, 16'd18, 16'd21);
    chk(32'(o_spc), 32'h06);
    wr(mss_pkg::OFS_CTRL, 32'h09);
    // a packet launched just before the write is still counted
    cyc(2);
    c = cnt1;
    cyc(100);
    chk(32'(cnt1), 32'(c));
    wr(mss_pkg::OFS_CTRL, 32'h0);
    $display("audio test done");
  endtask

  task automatic t_video();
    logic [15:0] c;
    i_vid_pkt_rdy <= 1'b1;
    wr(mss_pkg::OFS_TROFF, 32'h2);
    wr(mss_pkg::OFS_CTRL, 32'h23);
    c = vcnt;
    frame();
    cyc(90);
    chk(32'(vcnt), 32'(c));
    cyc(20);
    rng(vcnt - c, 16'd1, 16'd20);
    chk(32'(o_pay_len), 32'h5a0);
    chk(32'(o_util_mbps), 32'h3e8);
    wr(mss_pkg::OFS_P2_UDP, 32'h1234abcd);
    cyc(2);
    chk({o_tx2_src_port, o_tx2_dst_port}, 32'h1234abcd);
    chk({o_tx1_src_port, o_tx1_dst_port}, 32'hffff0000);
    i_vblank <= 1'b1;
    cyc(2);
    c = vcnt;
    cyc(20);
    chk(32'(vcnt), 32'(c));
    i_vblank <= 1'b0;
    wr(mss_pkg::OFS_CTRL, 32'h13);
    // still sending until the frame start moves it back to waiting
    frame();
    cyc(1);
    c = vcnt;
    cyc(40);
    chk(32'(vcnt), 32'(c));
    cyc(20);
    rng(vcnt - c, 16'd1, 16'd20);
    chk(32'(o_pay_len), 32'h4ec);
    i_src_bw <= 16'h2328;
    @(posedge i_clk) i_fmt_chg <= 1'b1;
    @(posedge i_clk) i_fmt_chg <= 1'b0;
    cyc(3);
    rchk(mss_pkg::OFS_STAT, 32'h2, 32'h2);
    chk(32'(o_util_mbps), 32'h0);
    wr(mss_pkg::OFS_STAT, 32'h7);
    i_src_bw <= 16'h03e8;
    i_src_levelb <= 6'h01;
    wr(mss_pkg::OFS_CTRL, 32'h03);
    rchk(mss_pkg::OFS_STAT, 32'h1, 32'h1);
    rchk(mss_pkg::OFS_CTRL, 32'h1, 32'h0);
    wr(mss_pkg::OFS_STAT, 32'h1);
    i_src_levelb <= 6'h00;
    wr(mss_pkg::OFS_CTRL, 32'h603);
    rchk(mss_pkg::OFS_STAT, 32'h1, 32'h1);
    $display("video test done");
  endtask

  task automatic t_order();
    wr(mss_pkg::OFS_NCH, 32'h4);
    rchk(mss_pkg::OFS_CHS_LO, 32'hffffffff, 32'h04);
    wr(mss_pkg::OFS_CHORD, 32'h2);
    rchk(mss_pkg::OFS_CHORD, 32'h001f1f1f, 32'h00040000);
    wr(mss_pkg::OFS_CHORD, 32'h31);
    wr(mss_pkg::OFS_CHORD, 32'h51);
    rchk(mss_pkg::OFS_STAT, 32'h4, 32'h4);
    wr(mss_pkg::OFS_CHORD, 32'h3);
    rchk(mss_pkg::OFS_CHS_LO, 32'hffffffff, 32'h0262);
    $display("channel order test done");
  endtask

  initial begin
    cyc(4);
    i_rst_n <= 1'b1;
    t_regs();
    t_audio();
    t_video();
    t_order();
    end_sim();
  end
endmodule
